// >>> hdl/hfb_pkg.sv
package hfb_pkg;
   localparam int          ADDR_W        = 12;
   localparam int          DEPTH         = 512;
   localparam int          CNT_W         = 10;
   localparam int          WM_W          = 9;
   localparam logic [9:0]  CAP_SMALL     = 10'h0FF;
   localparam logic [9:0]  CAP_LARGE     = 10'h200;
   // Register indices; byte address is four times the index
   localparam logic [7:0]  IDX_CTRL      = 8'h02;
   localparam logic [7:0]  IDX_THRESH    = 8'h03;
   localparam logic [7:0]  IDX_COUNT     = 8'h04;
   localparam logic [7:0]  IDX_PORT      = 8'h05;
   localparam logic [7:0]  IDX_STATUS    = 8'h06;
   localparam logic [7:0]  IDX_MASK      = 8'h07;
   localparam logic [7:0]  IDX_WINDOW    = 8'h08;
   localparam logic [7:0]  IDX_POINTER   = 8'h09;
   // Control field positions
   localparam int          B_DEPTH_SEL   = 7;
   localparam int          B_NEAR_FULL   = 6;
   localparam int          B_NEAR_EMPTY  = 5;
   localparam int          B_CLEAR       = 4;
   localparam int          B_THRESH_MSB  = 2;
   // Status and mask field positions
   localparam int          B_EV_FULL     = 1;
   localparam int          B_EV_EMPTY    = 0;
   // Reset values
   localparam logic        RST_DEPTH_SEL = 1'b0;
   localparam logic [7:0]  RST_THRESH    = 8'h00;
   localparam logic [9:0]  RST_COUNT     = 10'h000;
   localparam logic [1:0]  RST_MASK      = 2'h0;
   localparam logic [7:0]  RST_POINTER   = 8'h00;
endpackage

// >>> hdl/hfb_mem_if.sv
`timescale 1ns/100ps
interface hfb_mem_if;
   logic       push;
   logic       pop;
   logic       clear;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl  (output push, output pop, output clear, output wdata, input rdata);
   modport store (input push, input pop, input clear, input wdata, output rdata);
endinterface

// >>> hdl/hfb_store.sv
`timescale 1ns/100ps
module hfb_store #(
   parameter int DEPTH = hfb_pkg::DEPTH
) (
   // Clock and reset
   input  wire logic  pclk,
   input  wire logic  presetn,
   // Controller side
   hfb_mem_if.store   mem
);
   localparam int PW = $clog2(DEPTH);

   if (DEPTH < 512 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("hfb_store: DEPTH must be a power of two of at least 512");
   end

   logic [7:0]    ram [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;

   // Pointers wrap freely; the controller keeps the count within capacity
   assign mem.rdata = ram[rd_q];

   always_ff @(posedge pclk) begin
      if (mem.push) begin
         ram[wr_q] <= mem.wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (mem.clear) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (mem.push) wr_q <= wr_q + 1'b1;
         if (mem.pop)  rd_q <= rd_q + 1'b1;
      end
   end
endmodule

// >>> hdl/hfb_top.sv
`timescale 1ns/100ps
module hfb_top (
   // Clock and reset
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // APB slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [hfb_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic [31:0]                     prdata,
   output logic                            pready,
   output logic                            pslverr,
   // Interrupt
   output logic                            irq
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic                       depth_sel_q;
   logic                       thresh_msb_q;
   logic [7:0]                 thresh_q;
   logic [hfb_pkg::CNT_W-1:0]  count_q;
   logic [1:0]                 status_q;
   logic [1:0]                 mask_q;
   logic [7:0]                 pointer_q;
   logic                       full_prev_q;
   logic                       empty_prev_q;
   logic                       pready_q;
   logic                       pslverr_q;
   logic [31:0]                prdata_q;
   logic                       irq_q;

   hfb_mem_if mem ();

   hfb_store #(.DEPTH(hfb_pkg::DEPTH)) u_store (
      .pclk    (pclk),
      .presetn (presetn),
      .mem     (mem.store)
   );

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire        access    = psel & penable;
   wire        capture   = access & ~pready_q;
   wire        done      = access & pready_q;
   wire        wr_done   = done & pwrite;
   wire        rd_done   = done & ~pwrite;
   wire        aligned   = (paddr[1:0] == 2'h0) && (paddr[hfb_pkg::ADDR_W-1:10] == '0);
   wire [7:0]  bus_idx   = paddr[9:2];
   wire        is_window = aligned && bus_idx == hfb_pkg::IDX_WINDOW;
   // Window accesses reach the register under the access pointer, except the pointer register itself
   wire [7:0]  eff_idx   = is_window ? pointer_q : bus_idx;
   wire        hit_ctrl  = aligned && eff_idx == hfb_pkg::IDX_CTRL;
   wire        hit_thr   = aligned && eff_idx == hfb_pkg::IDX_THRESH;
   wire        hit_cnt   = aligned && eff_idx == hfb_pkg::IDX_COUNT;
   wire        hit_port  = aligned && eff_idx == hfb_pkg::IDX_PORT;
   wire        hit_stat  = aligned && eff_idx == hfb_pkg::IDX_STATUS;
   wire        hit_mask  = aligned && eff_idx == hfb_pkg::IDX_MASK;
   wire        hit_ptr   = aligned && bus_idx == hfb_pkg::IDX_POINTER;
   wire        mapped    = hit_ctrl | hit_thr | hit_cnt | hit_port | hit_stat
                         | hit_mask | hit_ptr;

   // ----------------------------------------------------------------
   // Level arithmetic
   // ----------------------------------------------------------------
   wire [9:0]  capacity  = depth_sel_q ? hfb_pkg::CAP_SMALL : hfb_pkg::CAP_LARGE;
   wire [9:0]  threshold = {1'b0, thresh_msb_q & ~depth_sel_q, thresh_q};
   wire [9:0]  room      = capacity - count_q;
   wire        near_full_flag  = room <= threshold;
   wire        near_empty_flag = count_q <= threshold;
   wire        is_full   = count_q >= capacity;
   wire        is_empty  = count_q == '0;
   wire        clear_req = wr_done & hit_ctrl & pwdata[hfb_pkg::B_CLEAR];
   wire        push_ok   = wr_done & hit_port & ~is_full;
   wire        pop_ok    = rd_done & hit_port & ~is_empty;
   wire [1:0]  events    = {near_full_flag & ~full_prev_q, near_empty_flag & ~empty_prev_q};
   wire [1:0]  w1c       = (wr_done & hit_stat) ? pwdata[1:0] : 2'h0;

   assign mem.push  = push_ok;
   assign mem.pop   = pop_ok;
   assign mem.clear = clear_req;
   assign mem.wdata = pwdata[7:0];

   wire [7:0]  ctrl_view = {depth_sel_q, near_full_flag, near_empty_flag, 1'b0, 1'b0,
                            thresh_msb_q, count_q[9:8]};
   wire [7:0]  rd_byte   = hit_ctrl ? ctrl_view
                         : hit_thr  ? thresh_q
                         : hit_cnt  ? count_q[7:0]
                         : hit_port ? (is_empty ? 8'h00 : mem.rdata)
                         : hit_stat ? {6'h00, status_q}
                         : hit_mask ? {6'h00, mask_q}
                         : hit_ptr  ? pointer_q
                         : 8'h00;

   // ----------------------------------------------------------------
   // APB answer: one wait state, then pready
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= capture;
         pslverr_q <= capture & ~mapped;
         if (capture) prdata_q <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         depth_sel_q  <= hfb_pkg::RST_DEPTH_SEL;
         thresh_msb_q <= 1'b0;
         thresh_q     <= hfb_pkg::RST_THRESH;
         mask_q       <= hfb_pkg::RST_MASK;
      end else if (wr_done) begin
         if (hit_ctrl) begin
            depth_sel_q  <= pwdata[hfb_pkg::B_DEPTH_SEL];
            thresh_msb_q <= pwdata[hfb_pkg::B_THRESH_MSB];
         end
         if (hit_thr)  thresh_q <= pwdata[7:0];
         if (hit_mask) mask_q   <= pwdata[1:0];
      end
   end

   // Pointer steps after every window access except to the data port,
   // so a burst keeps streaming into the buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pointer_q <= hfb_pkg::RST_POINTER;
      end else if (wr_done & hit_ptr) begin
         pointer_q <= pwdata[7:0];
      end else if (done & is_window & (pointer_q != hfb_pkg::IDX_PORT)) begin
         pointer_q <= pointer_q + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // Fill count
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= hfb_pkg::RST_COUNT;
      end else if (clear_req) begin
         count_q <= '0;
      end else if (push_ok) begin
         count_q <= count_q + 10'h001;
      end else if (pop_ok) begin
         count_q <= count_q - 10'h001;
      end
   end

   // ----------------------------------------------------------------
   // Sticky events and interrupt; a new event beats a same-cycle clear
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         full_prev_q  <= 1'b0;
         empty_prev_q <= 1'b0;
         status_q     <= 2'h0;
         irq_q        <= 1'b0;
      end else begin
         full_prev_q  <= near_full_flag;
         empty_prev_q <= near_empty_flag;
         status_q     <= (status_q & ~w1c) | events;
         irq_q        <= |(((status_q & ~w1c) | events) & mask_q);
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign irq     = irq_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence apb_setup_s;
      psel && !penable;
   endsequence
   sequence apb_access_s;
      psel && penable && !pready;
   endsequence

   apb_wait_a: assert property (apb_setup_s ##1 apb_access_s |=> pready)
      else $error("APB answer not one wait state");
   count_cap_a: assert property (count_q <= capacity)
      else $error("Fill count above capacity");
   near_full_a: assert property (capture && !pwrite && hit_ctrl
         |=> prdata[6] == ($past(capacity) - $past(count_q) <= $past(threshold)))
      else $error("Near-full read wrong");
   near_empty_a: assert property (capture && !pwrite && hit_ctrl
         |=> prdata[5] == ($past(count_q) <= $past(threshold)))
      else $error("Near-empty read wrong");
   clear_empty_a: assert property (clear_req |=> count_q == 10'h000)
      else $error("Clear did not empty buffer");
   clear_read_a: assert property (capture && !pwrite && hit_ctrl |=> !prdata[4])
      else $error("Clear bit read as one");
   thresh_small_a: assert property (depth_sel_q
         |-> near_empty_flag == (count_q <= {2'h0, thresh_q}))
      else $error("Threshold msb used in small mode");
   upper_read_a: assert property (capture && !pwrite && hit_ctrl
         |=> prdata[1:0] == $past(count_q[9:8]))
      else $error("Count upper bits wrong");
   thresh_store_a: assert property (wr_done && hit_thr |=> thresh_q == $past(pwdata[7:0]))
      else $error("Threshold write lost");
   count_low_a: assert property (capture && !pwrite && hit_cnt
         |=> prdata[7:0] == $past(count_q[7:0]))
      else $error("Fill count read wrong");
   push_step_a: assert property (push_ok && !clear_req |=> count_q == $past(count_q) + 10'h001)
      else $error("Push did not count up");
   pop_step_a: assert property (pop_ok |=> count_q == $past(count_q) - 10'h001)
      else $error("Pop did not count down");
   ptr_hold_a: assert property (done && is_window && pointer_q == hfb_pkg::IDX_PORT
         |=> $stable(pointer_q))
      else $error("Pointer moved on data port");
   event_latch_a: assert property ($rose(near_full_flag) |=> status_q[hfb_pkg::B_EV_FULL])
      else $error("Near-full event not latched");
   full_drop_a: assert property (wr_done && hit_port && is_full |=> $stable(count_q))
      else $error("Push into full buffer counted");
endmodule

// >>> sim/hfb_host_model.sv
`timescale 1ns/100ps
module hfb_host_model (
   // Clock
   input  wire logic                       pclk,
   // APB master side
   output logic                            psel,
   output logic                            penable,
   output logic                            pwrite,
   output logic [hfb_pkg::ADDR_W-1:0]      paddr,
   output logic [31:0]                     pwdata,
   input  wire logic [31:0]                prdata,
   input  wire logic                       pready,
   input  wire logic                       pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = '0;
      pwdata  = 32'h0000_0000;
   end

   // ----------------------------------------
   // One transfer, setup then access phase
   // ----------------------------------------
   // Starts one edge after the previous release, so no signal is driven twice in a step
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h00_0000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      // Read before this edge's updates land: the value sampled at the edge
      do @(posedge pclk); while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// >>> sim/testbench.sv
`timescale 1ns/100ps
module testbench;
   logic                       pclk;
   logic                       presetn;
   logic                       psel;
   logic                       penable;
   logic                       pwrite;
   logic [hfb_pkg::ADDR_W-1:0] paddr;
   logic [31:0]                pwdata;
   logic [31:0]                prdata;
   logic                       pready;
   logic                       pslverr;
   logic                       irq;
   logic [31:0]                rd;
   logic                       err;
   int                         num_errors;
   int                         checks;

   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   hfb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
                .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                .pready(pready), .pslverr(pslverr), .irq(irq));

   hfb_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
                        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                        .pready(pready), .pslverr(pslverr));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] val);
      host.xfer(1'b1, idx, val, rd, err);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
      host.xfer(1'b0, idx, 8'h00, rd, err);
      check({31'h0, err}, 32'h0000_0000, what);
      check(rd, {24'h00_0000, exp}, what);
   endtask

   task automatic push_n(input int n);
      for (int k = 0; k < n; k++) wr(hfb_pkg::IDX_PORT, 8'(k));
   endtask

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Full run is well under ten thousand cycles
   initial begin
      repeat (50000) @(posedge pclk);
      num_errors++;
      stop_test();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      num_errors = 0;
      checks     = 0;
      presetn    = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(hfb_pkg::IDX_COUNT, 8'h00, "count reset");
      rd_chk(hfb_pkg::IDX_CTRL, 8'h20, "ctrl reset");
      rd_chk(hfb_pkg::IDX_THRESH, 8'h00, "threshold reset");
      $display("TEST reset done");
      wr(hfb_pkg::IDX_THRESH, 8'hA5);
      rd_chk(hfb_pkg::IDX_THRESH, 8'hA5, "threshold A5");
      wr(hfb_pkg::IDX_THRESH, 8'h5A);
      rd_chk(hfb_pkg::IDX_THRESH, 8'h5A, "threshold 5A");
      wr(hfb_pkg::IDX_THRESH, 8'h02);
      push_n(3);
      rd_chk(hfb_pkg::IDX_COUNT, 8'h03, "count after push");
      rd_chk(hfb_pkg::IDX_CTRL, 8'h00, "near empty off");
      rd_chk(hfb_pkg::IDX_PORT, 8'h00, "first byte out");
      rd_chk(hfb_pkg::IDX_COUNT, 8'h02, "count after pop");
      rd_chk(hfb_pkg::IDX_CTRL, 8'h20, "near empty at threshold");
      wr(hfb_pkg::IDX_CTRL, 8'h10);
      rd_chk(hfb_pkg::IDX_COUNT, 8'h00, "count after clear");
      rd_chk(hfb_pkg::IDX_CTRL, 8'h20, "clear bit reads zero");
      $display("TEST basic done");
      wr(hfb_pkg::IDX_THRESH, 8'h00);
      push_n(300);
      rd_chk(hfb_pkg::IDX_COUNT, 8'h2C, "count low 300");
      rd_chk(hfb_pkg::IDX_CTRL, 8'h01, "count upper 300");
      push_n(212);
      wr(hfb_pkg::IDX_PORT, 8'hEE);
      rd_chk(hfb_pkg::IDX_COUNT, 8'h00, "count low full");
      rd_chk(hfb_pkg::IDX_CTRL, 8'h42, "full 512 flags");
      wr(hfb_pkg::IDX_CTRL, 8'h04);
      rd_chk(hfb_pkg::IDX_CTRL, 8'h46, "threshold msb set");
      for (int k = 0; k < 256; k++) rd_chk(hfb_pkg::IDX_PORT, 8'(k), "drain order");
      rd_chk(hfb_pkg::IDX_CTRL, 8'h65, "flags at 256");
      $display("TEST large done");
      wr(hfb_pkg::IDX_CTRL, 8'h10);
      wr(hfb_pkg::IDX_CTRL, 8'h80);
      push_n(256);
      rd_chk(hfb_pkg::IDX_COUNT, 8'hFF, "small capacity");
      rd_chk(hfb_pkg::IDX_CTRL, 8'hC0, "small full flags");
      wr(hfb_pkg::IDX_CTRL, 8'h84);
      rd_chk(hfb_pkg::IDX_CTRL, 8'hC4, "msb ignored small");
      wr(hfb_pkg::IDX_CTRL, 8'h90);
      rd_chk(hfb_pkg::IDX_PORT, 8'h00, "pop empty");
      rd_chk(hfb_pkg::IDX_COUNT, 8'h00, "count stays zero");
      $display("TEST small done");
      wr(hfb_pkg::IDX_POINTER, 8'h05);
      wr(hfb_pkg::IDX_WINDOW, 8'hA1);
      wr(hfb_pkg::IDX_WINDOW, 8'hA2);
      wr(hfb_pkg::IDX_WINDOW, 8'hA3);
      rd_chk(hfb_pkg::IDX_POINTER, 8'h05, "pointer held");
      rd_chk(hfb_pkg::IDX_COUNT, 8'h03, "burst pushed");
      rd_chk(hfb_pkg::IDX_PORT, 8'hA1, "burst data");
      wr(hfb_pkg::IDX_POINTER, 8'h03);
      wr(hfb_pkg::IDX_WINDOW, 8'h11);
      rd_chk(hfb_pkg::IDX_THRESH, 8'h11, "window write");
      rd_chk(hfb_pkg::IDX_POINTER, 8'h04, "pointer advances");
      $display("TEST window done");
      wr(hfb_pkg::IDX_CTRL, 8'h90);
      wr(hfb_pkg::IDX_THRESH, 8'h00);
      wr(hfb_pkg::IDX_STATUS, 8'h03);
      rd_chk(hfb_pkg::IDX_STATUS, 8'h00, "status cleared");
      wr(hfb_pkg::IDX_MASK, 8'h02);
      check({31'h0, irq}, 32'h0000_0000, "irq idle");
      wr(hfb_pkg::IDX_THRESH, 8'hFF);
      rd_chk(hfb_pkg::IDX_STATUS, 8'h02, "near full event");
      check({31'h0, irq}, 32'h0000_0001, "irq raised");
      wr(hfb_pkg::IDX_MASK, 8'h00);
      rd_chk(hfb_pkg::IDX_MASK, 8'h00, "mask readback");
      check({31'h0, irq}, 32'h0000_0000, "irq masked");
      wr(hfb_pkg::IDX_STATUS, 8'h02);
      rd_chk(hfb_pkg::IDX_STATUS, 8'h00, "event stays cleared");
      wr(hfb_pkg::IDX_PORT, 8'h77);
      wr(hfb_pkg::IDX_THRESH, 8'h00);
      wr(hfb_pkg::IDX_STATUS, 8'h03);
      wr(hfb_pkg::IDX_MASK, 8'h01);
      check({31'h0, irq}, 32'h0000_0000, "irq quiet");
      rd_chk(hfb_pkg::IDX_PORT, 8'h77, "last byte out");
      rd_chk(hfb_pkg::IDX_STATUS, 8'h01, "near empty event");
      check({31'h0, irq}, 32'h0000_0001, "irq empty event");
      host.xfer(1'b0, 8'h30, 8'h00, rd, err);
      check({31'h0, err}, 32'h0000_0001, "unmapped error");
      check(rd, 32'h0000_0000, "unmapped data");
      $display("TEST events done");
      // Reset with data held, then the buffer must come back empty
      wr(hfb_pkg::IDX_PORT, 8'h55);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(hfb_pkg::IDX_COUNT, 8'h00, "count after reset");
      rd_chk(hfb_pkg::IDX_CTRL, 8'h20, "ctrl after reset");
      rd_chk(hfb_pkg::IDX_MASK, 8'h00, "mask after reset");
      check({31'h0, irq}, 32'h0000_0000, "irq after reset");
      $display("TEST second reset done");
      stop_test();
   end
endmodule
